/* File: setpoint_relay_control.sv */
// Purpose: setpoint storage, pressure capture, display timing and relay channels
// Assumes: display bus and register port on clk; buttons, switches and gauge state are pins
// Notes:   setpoint storage is modelled by flops that commit after the show period
// Behaviour
// - setpoints stored as two digits, two-digit exponent
// - accept setpoints from 1e-12 to 9e5
// - compare setpoint directly with display pressure
// - unit change leaves stored setpoints untouched
// - ten percent hysteresis on every channel
// - activate one count below setpoint, falling
// - deactivate at setpoint plus tenth plus one
// - second digit five or more rounds up
// - hold last pressure while setpoints shown
// - right forces on, left off, centre automatic
// - override beats comparison at any time
// - negative reading shows minus, zero lone zero
// - gauge off forces first two relays inactive unless right override
// - setpoint shown two seconds after button release
// - new setpoint stored when display returns
`timescale 1ns/1ps
`default_nettype none

module setpoint_relay_control
  import setpoint_pkg::*;
#(
  parameter int unsigned NCH         = 6,
  parameter int unsigned SHOW_CYCLES = `SHOW_CYCLES
)(
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic [7:0]         addr,
  input  wire logic [31:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic [31:0]             rdata,
  input  wire logic               disp_valid,
  input  wire logic [15:0]        disp_data,
  input  wire logic               disp_is_setpoint,
  input  wire logic               set_btn,
  input  wire logic               gauge_on,
  input  wire logic [1:0]         unit_select,
  input  wire logic [NCH-1:0]     ovr_right,
  input  wire logic [NCH-1:0]     ovr_left,
  input  wire logic signed [15:0] cm_reading,
  output logic [NCH-1:0]          process_relay_outputs,
  output logic                    show_setpoint,
  output logic [15:0]             shown_setpoint,
  output logic                    line3_minus,
  output logic                    line3_lone_zero
);

  localparam int unsigned CNT_W = $clog2(SHOW_CYCLES + 1);
  localparam int unsigned SEL_W = (NCH > 1) ? $clog2(NCH) : 1;
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SHOW_CYCLES - 1);

  typedef struct packed {
    logic [1:0]           btn_s;
    logic [1:0]           gauge_s;
    logic [1:0]           unit_s1;
    logic [1:0]           unit_s2;
    logic [NCH-1:0]       right_s1;
    logic [NCH-1:0]       right_s2;
    logic [NCH-1:0]       left_s1;
    logic [NCH-1:0]       left_s2;
    sci_t                 held;
    logic                 held_valid;
    sci_t [NCH-1:0]       nv;
    sci_t [NCH-1:0]       edit;
    logic [NCH-1:0]       dirty;
    logic [SEL_W-1:0]     sel;
    disp_mode_t           mode;
    logic [CNT_W-1:0]     cnt;
    logic                 rej;
    logic [31:0]          rdata;
    logic [15:0]          shown;
    logic                 minus;
    logic                 zero;
  } state_t;

  state_t          st;
  state_t          next_st;
  logic [NCH-1:0]  relay_vec;
  logic            btn;
  logic            wr_sp_hit;
  logic [SEL_W-1:0] wr_sp_idx;
  logic            rd_sp_hit;
  logic [SEL_W-1:0] rd_sp_idx;
  sci_t            wr_val;
  logic            hold_pressure;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode for the setpoint window, shared by read and write
  function automatic logic sp_hit(input logic [7:0] a);
    logic [7:0] off;
    off    = a - `REG_SETPOINT_BASE;
    sp_hit = (a >= `REG_SETPOINT_BASE) && (off[1:0] == 2'b00) && ({2'b00, off[7:2]} < 8'(NCH));
  endfunction : sp_hit

  function automatic logic [SEL_W-1:0] sp_idx(input logic [7:0] a);
    logic [7:0] off;
    off    = a - `REG_SETPOINT_BASE;
    sp_idx = SEL_W'({2'b00, off[7:2]});
  endfunction : sp_idx

  ////////////////////////////////////////////////////////////////////////////////
  // decode helpers feeding the next-state logic
  always_comb begin
    wr_sp_hit = wr && sp_hit(addr);
    wr_sp_idx = sp_idx(addr);
    rd_sp_hit = rd && sp_hit(addr);
    rd_sp_idx = sp_idx(addr);
    wr_val    = sci_t'(wdata[15:0]);
    btn       = st.btn_s[1];
    // pressure capture freezes while a setpoint is up or the button is held
    hold_pressure = (st.mode == DISP_SETPOINT) || btn || disp_is_setpoint;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state: synchronisers, capture, setpoint edit and commit, register port
  always_comb begin
    next_st = st;

    // pin synchronisers; first stage feeds only the second
    next_st.btn_s    = {st.btn_s[0], set_btn};
    next_st.gauge_s  = {st.gauge_s[0], gauge_on};
    next_st.unit_s1  = unit_select;
    next_st.unit_s2  = st.unit_s1;
    next_st.right_s1 = ovr_right;
    next_st.right_s2 = st.right_s1;
    next_st.left_s1  = ovr_left;
    next_st.left_s2  = st.left_s1;

    // pressure capture from the display bus
    if (disp_valid && !hold_pressure) begin
      next_st.held       = sci_t'(disp_data);
      next_st.held_valid = 1'b1;
    end

    // manometer line-three indications
    next_st.minus = cm_reading[15];
    next_st.zero  = (cm_reading == 16'sh0000);

    // display mode: shown while held, then a fixed period after release
    unique case (st.mode)
      DISP_PRESSURE: begin
        if (btn || wr_sp_hit) begin
          next_st.mode = DISP_SETPOINT;
          next_st.cnt  = CNT_LOAD;
        end
      end
      DISP_SETPOINT: begin
        if (btn || wr_sp_hit) begin
          next_st.cnt = CNT_LOAD;
        end else if (st.cnt == '0) begin
          next_st.mode = DISP_PRESSURE;
          // commit edited values as the display goes back to pressure
          for (int i = 0; i < NCH; i++) begin
            if (st.dirty[i]) next_st.nv[i] = st.edit[i];
          end
          next_st.dirty = '0;
        end else begin
          next_st.cnt = st.cnt - CNT_W'(1);
        end
      end
    endcase

    // register writes; unit selection never reaches stored setpoints
    if (wr && (addr == `REG_CTRL)) begin
      next_st.sel = wdata[SEL_W-1:0];
      if (wdata[`CTRL_REJ_CLR_BIT]) next_st.rej = 1'b0;
    end
    if (wr_sp_hit) begin
      if (sp_valid(wr_val)) begin
        next_st.edit[wr_sp_idx]  = wr_val;
        next_st.dirty[wr_sp_idx] = 1'b1;
        next_st.sel              = wr_sp_idx;
      end else begin
        next_st.rej = 1'b1;
      end
    end

    // displayed setpoint word, registered
    next_st.shown = 16'h0000;
    if (next_st.mode == DISP_SETPOINT && 32'(next_st.sel) < NCH) begin
      next_st.shown = next_st.edit[next_st.sel];
    end

    // read data stand one cycle after the strobe and only then
    next_st.rdata = 32'h0000_0000;
    if (rd) begin
      if (addr == `REG_CTRL) begin
        next_st.rdata = 32'(st.sel);
      end else if (addr == `REG_STATUS) begin
        next_st.rdata[`STAT_MODE_BIT]       = st.mode;
        next_st.rdata[`STAT_HELD_VALID_BIT] = st.held_valid;
        next_st.rdata[`STAT_REJ_BIT]        = st.rej;
        next_st.rdata[`STAT_UNIT_LSB +: 2]  = st.unit_s2;
        next_st.rdata[`STAT_RELAY_LSB +: NCH] = relay_vec;
      end else if (addr == `REG_HELD_PRESSURE) begin
        next_st.rdata = {16'h0000, st.held};
      end else if (rd_sp_hit) begin
        next_st.rdata = {16'h0000, st.nv[rd_sp_idx]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register; storage comes up at the default setpoint
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st      <= '0;
      st.nv   <= {NCH{`SP_RESET}};
      st.edit <= {NCH{`SP_RESET}};
      st.mode <= DISP_PRESSURE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one comparison channel per relay; compare against stored values only
  for (genvar gi = 0; gi < NCH; gi++) begin : g_ch
    relay_if link();

    assign link.sp        = st.nv[gi];
    assign link.pressure  = st.held;
    assign link.force_on  = st.right_s2[gi];
    assign link.force_off = st.left_s2[gi] && !st.right_s2[gi];
    // first channels drop out with the ion gauge; all wait for a first pressure
    assign link.block     = !st.held_valid ||
                            ((gi < `GAUGE_CH_COUNT) && !st.gauge_s[1]);

    relay_channel u_ch (
      .clk    (clk),
      .resetn (resetn),
      .link   (link.chan)
    );

    assign relay_vec[gi] = link.active;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign rdata                 = st.rdata;
  assign process_relay_outputs = relay_vec;
  assign show_setpoint         = (st.mode == DISP_SETPOINT);
  assign shown_setpoint        = st.shown;
  assign line3_minus           = st.minus;
  assign line3_lone_zero       = st.zero && !st.minus;

endmodule : setpoint_relay_control

`default_nettype wire

/* File: setpoint_cfg.svh */
// Purpose: constants for the setpoint relay block: register map, field positions, resets, timing
// Assumes: 25 MHz clock, setpoint words packed as {exponent, first digit, second digit}
// Notes:   definitions only
`ifndef SETPOINT_CFG_SVH
`define SETPOINT_CFG_SVH

// register offsets (byte addresses, one word each)
`define REG_CTRL            8'h00
`define REG_STATUS          8'h04
`define REG_HELD_PRESSURE   8'h08
`define REG_SETPOINT_BASE   8'h10

// field positions
`define SCI_EXP_LSB         8
`define SCI_D1_LSB          4
`define SCI_D2_LSB          0
`define CTRL_REJ_CLR_BIT    8
`define STAT_MODE_BIT       0
`define STAT_HELD_VALID_BIT 1
`define STAT_REJ_BIT        2
`define STAT_UNIT_LSB       4
`define STAT_RELAY_LSB      8

// setpoint range limits and reset value (1.0 x 10^-6)
`define SP_EXP_MIN          8'shF4
`define SP_EXP_MAX          8'sh05
`define SP_MANT_AT_MAX      8'h5A
`define SP_RESET            16'hFA10
`define SP_ROUND_DIGIT      4'h5

// channels gated by the ion gauge state
`define GAUGE_CH_COUNT      2

// timing: setpoint shown for this long after the button lets go
`define CLK_HZ              25000000
`define SHOW_TIME_MS        2000
`define SHOW_CYCLES         (`SHOW_TIME_MS * (`CLK_HZ / 1000))

`endif

/* File: setpoint_pkg.sv */
// Purpose: shared types and value helpers for the setpoint relay block
// Assumes: values are d1.d2 x 10^exp with decimal digits
// Notes:   comparison helpers rank exponent first
`include "setpoint_cfg.svh"

package setpoint_pkg;

  typedef struct packed {
    logic signed [7:0] exp;
    logic [3:0]        d1;
    logic [3:0]        d2;
  } sci_t;

  typedef enum logic {
    DISP_PRESSURE = 1'b0,
    DISP_SETPOINT = 1'b1
  } disp_mode_t;

  // two digits folded into an integer mantissa, 0..99
  function automatic logic [7:0] mant(input sci_t v);
    mant = {4'h0, v.d1} * 8'h0A + {4'h0, v.d2};
  endfunction : mant

  // a < b, exponent first, mantissa second; mantissas may exceed 99 (thresholds)
  function automatic logic sci_lt(input logic [7:0] ma, input logic signed [7:0] ea,
                                  input logic [7:0] mb, input logic signed [7:0] eb);
    logic [11:0] a10;
    logic [11:0] b10;
    a10 = {4'h0, ma} * 12'h00A;
    b10 = {4'h0, mb} * 12'h00A;
    if (ma == 8'h00) sci_lt = (mb != 8'h00);
    else if (ea == eb) sci_lt = (ma < mb);
    else if (ea == eb + 8'sh01) sci_lt = (a10 < {4'h0, mb});
    else if (eb == ea + 8'sh01) sci_lt = ({4'h0, ma} < b10);
    else sci_lt = (ea < eb);
  endfunction : sci_lt

  // accepted range is 1.0e-12 up to 9.0e5
  function automatic logic sp_valid(input sci_t v);
    sp_valid = (v.d1 >= 4'h1) && (v.d1 <= 4'h9) && (v.d2 <= 4'h9) &&
               (v.exp >= `SP_EXP_MIN) && (v.exp <= `SP_EXP_MAX) &&
               !((v.exp == `SP_EXP_MAX) && (mant(v) > `SP_MANT_AT_MAX));
  endfunction : sp_valid

endpackage : setpoint_pkg

/* File: relay_if.sv */
// Purpose: carries one channel's setpoint, pressure and override between top and channel logic
// Assumes: single clock domain
// Notes:   ctl side drives inputs, chan side returns relay state
`timescale 1ns/1ps
`default_nettype none

interface relay_if;
  import setpoint_pkg::*;
  sci_t sp;
  sci_t pressure;
  logic force_on;
  logic force_off;
  logic block;
  logic active;
  modport ctl  (output sp, output pressure, output force_on, output force_off, output block, input active);
  modport chan (input sp, input pressure, input force_on, input force_off, input block, output active);
endinterface : relay_if

`default_nettype wire

/* File: relay_channel.sv */
// Purpose: one relay channel: hysteresis comparison plus manual override
// Assumes: pressure and setpoint are stable registered values
// Notes:   relay state is a flop; no change while the pressure sits inside the band
`timescale 1ns/1ps
`default_nettype none

module relay_channel
  import setpoint_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  relay_if.chan     link
);

  typedef struct packed {
    logic active;
  } ch_state_t;

  ch_state_t   st;
  ch_state_t   next_st;
  logic [7:0]  sp_m;
  logic [7:0]  hyst;
  logic [7:0]  off_m;
  logic [7:0]  p_m;

  ////////////////////////////////////////////////////////////////////////////////
  // thresholds: hysteresis is a tenth, rounded up when the second digit is 5+
  always_comb begin
    sp_m  = mant(link.sp);
    p_m   = mant(link.pressure);
    hyst  = sp_m / 8'h0A + ((link.sp.d2 >= `SP_ROUND_DIGIT) ? 8'h01 : 8'h00);
    off_m = sp_m + hyst + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // relay decision, override first, then gating, then the band
  always_comb begin
    next_st = st;
    if (link.force_on) begin
      next_st.active = 1'b1;
    end else if (link.force_off) begin
      next_st.active = 1'b0;
    end else if (link.block) begin
      next_st.active = 1'b0;
    end else if (sci_lt(p_m, link.pressure.exp, sp_m, link.sp.exp)) begin
      next_st.active = 1'b1;
    end else if (!sci_lt(p_m, link.pressure.exp, off_m, link.sp.exp)) begin
      next_st.active = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) st <= '0;
    else         st <= next_st;
  end

  assign link.active = st.active;

endmodule : relay_channel

`default_nettype wire

/* File: relay_load_model.sv */
// Purpose: process equipment hanging on the relay contacts
// Assumes: one clock, contacts sampled on the rising edge
// Notes:   contactor pulls in one cycle late; closures counts channel 0 pull-ins
`timescale 1ns/1ps
`default_nettype none

module relay_load_model #(
  parameter int unsigned NCH = 6
)(
  input  wire logic           clk,
  input  wire logic           resetn,
  input  wire logic [NCH-1:0] contacts,
  output logic [NCH-1:0]      engaged,
  output logic [7:0]          closures
);
  // a real contactor lags its coil, so the load never sees a relay change at once
  always_ff @(posedge clk) begin
    if (!resetn) begin
      engaged  <= '0;
      closures <= 8'h00;
    end else begin
      engaged <= contacts;
      if (contacts[0] && !engaged[0]) closures <= closures + 8'h01;
    end
  end
endmodule : relay_load_model

`default_nettype wire

/* File: setpoint_relay_control_monitor.sv */
// Purpose: port-level checker for the setpoint relay block
// Assumes: one clock, synchronous active-low reset
// Notes:   pins cross a two-flop synchroniser, hence the four-cycle windows
`timescale 1ns/1ps
`default_nettype none

module setpoint_relay_control_monitor #(
  parameter int unsigned NCH         = 6,
  parameter int unsigned SHOW_CYCLES = 20
)(
  input wire logic               clk,
  input wire logic               resetn,
  input wire logic [7:0]         addr,
  input wire logic [31:0]        wdata,
  input wire logic               wr,
  input wire logic               rd,
  input wire logic [31:0]        rdata,
  input wire logic               disp_valid,
  input wire logic [15:0]        disp_data,
  input wire logic               disp_is_setpoint,
  input wire logic               set_btn,
  input wire logic               gauge_on,
  input wire logic [1:0]         unit_select,
  input wire logic [NCH-1:0]     ovr_right,
  input wire logic [NCH-1:0]     ovr_left,
  input wire logic signed [15:0] cm_reading,
  input wire logic [NCH-1:0]     process_relay_outputs,
  input wire logic               show_setpoint,
  input wire logic [15:0]        shown_setpoint,
  input wire logic               line3_minus,
  input wire logic               line3_lone_zero
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // length of the current show period, to bound how early it may end
  logic [31:0] show_cnt;
  always_ff @(posedge clk) begin
    if (!resetn) show_cnt <= 32'h0;
    else if (show_setpoint) show_cnt <= show_cnt + 32'h1;
    else show_cnt <= 32'h0;
  end

  property p_reset; $rose(resetn) |-> rdata == 32'h0 && process_relay_outputs == '0 && !show_setpoint; endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_rd_idle; !rd |=> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
  property p_unmapped; rd && addr == 8'h0C |=> rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ovr_on; ovr_right[0] [*4] |-> process_relay_outputs[0]; endproperty
  a_ovr_on: assert property (p_ovr_on) else $error("right override not active");
  property p_ovr_off; (ovr_left[0] && !ovr_right[0]) [*4] |-> !process_relay_outputs[0]; endproperty
  a_ovr_off: assert property (p_ovr_off) else $error("left override not inactive");
  property p_gauge; (!gauge_on && ovr_right[1:0] == 2'b00) [*4] |-> process_relay_outputs[1:0] == 2'b00; endproperty
  a_gauge: assert property (p_gauge) else $error("gauge off left relay active");
  property p_show_start;
    wr && addr == 8'h10 && wdata[15:8] == 8'hFA && wdata[7:4] != 4'h0 && wdata[7:4] <= 4'h9 && wdata[3:0] <= 4'h9
      |=> show_setpoint && shown_setpoint == $past(wdata[15:0]);
  endproperty
  a_show_start: assert property (p_show_start) else $error("setpoint write not shown");
  property p_show_len; $fell(show_setpoint) |-> show_cnt >= SHOW_CYCLES; endproperty
  a_show_len: assert property (p_show_len) else $error("show period too short");
  property p_shown_zero; !show_setpoint |-> shown_setpoint == 16'h0000; endproperty
  a_shown_zero: assert property (p_shown_zero) else $error("shown word while not showing");
  property p_minus; cm_reading < 0 |=> line3_minus && !line3_lone_zero; endproperty
  a_minus: assert property (p_minus) else $error("negative reading not flagged");
  property p_zero; cm_reading == 16'sh0000 |=> line3_lone_zero && !line3_minus; endproperty
  a_zero: assert property (p_zero) else $error("zero reading not flagged");
endmodule : setpoint_relay_control_monitor

bind setpoint_relay_control setpoint_relay_control_monitor #(.NCH(NCH), .SHOW_CYCLES(SHOW_CYCLES)) i_mon (
  .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .disp_valid(disp_valid), .disp_data(disp_data), .disp_is_setpoint(disp_is_setpoint), .set_btn(set_btn),
  .gauge_on(gauge_on), .unit_select(unit_select), .ovr_right(ovr_right), .ovr_left(ovr_left),
  .cm_reading(cm_reading), .process_relay_outputs(process_relay_outputs), .show_setpoint(show_setpoint),
  .shown_setpoint(shown_setpoint), .line3_minus(line3_minus), .line3_lone_zero(line3_lone_zero));

`default_nettype wire

/* File: testbench.sv */
// Purpose: self-checking bench for the setpoint relay block
// Assumes: show period shortened to SHOW cycles
// Notes:   relays are judged four cycles after a pressure word lands
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int unsigned SHOW = 20;
  logic clk, resetn, wr, rd, disp_valid, disp_is_setpoint, set_btn, gauge_on;
  logic [7:0] addr, closures;
  logic [31:0] wdata, rdata;
  logic [15:0] disp_data, shown_setpoint;
  logic [1:0] unit_select;
  logic [5:0] ovr_right, ovr_left, relays, engaged;
  logic signed [15:0] cm_reading;
  logic show_setpoint, line3_minus, line3_lone_zero;
  int n_mismatch = 0;
  int samples_checked = 0;

  setpoint_relay_control #(.NCH(6), .SHOW_CYCLES(SHOW)) i_dut (.clk(clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .disp_valid(disp_valid), .disp_data(disp_data),
    .disp_is_setpoint(disp_is_setpoint), .set_btn(set_btn), .gauge_on(gauge_on), .unit_select(unit_select),
    .ovr_right(ovr_right), .ovr_left(ovr_left), .cm_reading(cm_reading), .process_relay_outputs(relays),
    .show_setpoint(show_setpoint), .shown_setpoint(shown_setpoint), .line3_minus(line3_minus),
    .line3_lone_zero(line3_lone_zero));
  relay_load_model #(.NCH(6)) i_load (.clk(clk), .resetn(resetn), .contacts(relays), .engaged(engaged),
    .closures(closures));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wreg
  // read data stand only in the cycle after the strobe, so sample right then
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rreg
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic set_p(input logic [15:0] p);
    @(posedge clk);
    disp_data <= p;
    settle(4);
  endtask : set_p
  task automatic step(input logic [15:0] p, input logic e);
    set_p(p);
    chk({31'h0, relays[0]}, {31'h0, e});
  endtask : step
  task automatic relall(input logic [5:0] e);
    chk({26'h0, relays}, {26'h0, e});
  endtask : relall

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    relall(6'h00);
    rreg(8'h10, 32'h0000FA10);
    rreg(8'h0C, 32'h0);
  endtask : t_regs
  // setpoint 6.3 then 6.6: band edges, rounding and a cross-decade value
  task automatic t_hyst;
    wreg(8'h10, 32'h0000FA63);
    settle(SHOW + 4);
    step(16'hFA80, 1'b0);
    step(16'hFA63, 1'b0);
    step(16'hFA62, 1'b1);
    step(16'hFA69, 1'b1);
    step(16'hFA70, 1'b0);
    step(16'hF999, 1'b1);
    step(16'hFB10, 1'b0);
    wreg(8'h10, 32'h0000FA66);
    settle(SHOW + 4);
    step(16'hFA66, 1'b0);
    step(16'hFA65, 1'b1);
    step(16'hFA73, 1'b1);
    step(16'hFA74, 1'b0);
    chk({24'h0, closures}, 32'h3);
  endtask : t_hyst
  task automatic t_hold;
    @(posedge clk);
    set_btn          <= 1'b1;
    disp_is_setpoint <= 1'b1;
    disp_data        <= 16'hF911;
    settle(6);
    chk({31'h0, relays[0]}, 32'h0);
    chk({15'h0, show_setpoint, shown_setpoint}, 32'h0001FA66);
    rreg(8'h08, 32'h0000FA74);
    @(posedge clk);
    set_btn          <= 1'b0;
    disp_is_setpoint <= 1'b0;
    disp_data        <= 16'hFA74;
    settle(SHOW + 6);
  endtask : t_hold
  task automatic t_units;
    @(posedge clk);
    unit_select <= 2'h2;
    settle(4);
    rreg(8'h04, 32'h00000022);
    rreg(8'h10, 32'h0000FA66);
    // a word without its valid flag must not be captured
    @(posedge clk);
    disp_valid <= 1'b0;
    set_p(16'hF811);
    rreg(8'h08, 32'h0000FA74);
    @(posedge clk);
    disp_valid <= 1'b1;
    disp_data  <= 16'hFA74;
  endtask : t_units
  // 9.1e5 lies just past the top of the range
  task automatic t_refused;
    // a refused write still brings up the display, so the mode bit reads set
    wreg(8'h14, 32'h00000591);
    rreg(8'h04, 32'h00000027);
    rreg(8'h14, 32'h0000FA10);
    wreg(8'h00, 32'h00000100);
    rreg(8'h04, 32'h00000023);
    wreg(8'h14, 32'h00000590);
    settle(SHOW + 4);
    rreg(8'h14, 32'h00000590);
  endtask : t_refused
  task automatic t_gauge;
    set_p(16'hF950);
    relall(6'h3F);
    @(posedge clk);
    gauge_on <= 1'b0;
    settle(5);
    relall(6'h3C);
    @(posedge clk);
    gauge_on <= 1'b1;
    settle(5);
    relall(6'h3F);
  endtask : t_gauge
  task automatic t_override;
    @(posedge clk);
    ovr_left  <= 6'h3F;
    ovr_right <= 6'h01;
    settle(5);
    relall(6'h01);
    set_p(16'hFB10);
    relall(6'h01);
    // channel 1 holds 9.0e5 by now, so it pulls in once released
    @(posedge clk);
    ovr_left  <= 6'h00;
    ovr_right <= 6'h00;
    settle(5);
    relall(6'h02);
    chk({26'h0, engaged}, 32'h00000002);
  endtask : t_override
  task automatic t_line3;
    @(posedge clk);
    cm_reading <= -16'sd5;
    settle(3);
    chk({30'h0, line3_minus, line3_lone_zero}, 32'h2);
    @(posedge clk);
    cm_reading <= 16'sd0;
    settle(3);
    chk({30'h0, line3_minus, line3_lone_zero}, 32'h1);
    @(posedge clk);
    cm_reading <= 16'sd7;
    settle(3);
    chk({30'h0, line3_minus, line3_lone_zero}, 32'h0);
  endtask : t_line3

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // a hang counts as a mismatch; the full run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    {resetn, wr, rd, disp_is_setpoint, set_btn} = 5'b0;
    {disp_valid, gauge_on} = 2'b11;
    addr = 8'h00;
    wdata = 32'h0;
    disp_data = 16'hFB10;
    unit_select = 2'h0;
    ovr_right = 6'h00;
    ovr_left = 6'h00;
    cm_reading = 16'sd7;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    settle(4);
    t_regs();
    t_hyst();
    t_hold();
    t_units();
    t_refused();
    t_gauge();
    t_override();
    t_line3();
    wrap_up();
  end
endmodule : testbench

`default_nettype wire
